// ---- dms_far_side.sv ----
`timescale 1ns/1ps
module dms_far_side
    import dms_pkg::*;
#(
    parameter int NUM_TERM = 7
) (
    // Clock
    input  wire logic           i_sys_clk,
    // Terminal pins
    output logic [NUM_TERM-1:0] o_terminal_in,
    output logic                o_output_stop_in,
    output logic                o_forward_start_in,
    output logic                o_reverse_start_in,
    // Panel and network requests
    output logic                o_mode_req_valid,
    output logic [1:0]          o_mode_req
);
    initial begin
        o_terminal_in      = '0;
        o_output_stop_in   = 1'b0;
        o_forward_start_in = 1'b0;
        o_reverse_start_in = 1'b0;
        o_mode_req_valid   = 1'b0;
        o_mode_req         = 2'h0;
    end

    // Pin levels change just after an edge and then hold.
    task automatic set_pins(input logic [NUM_TERM-1:0] t, input logic os,
                            input logic [1:0] st);
        @(posedge i_sys_clk);
        o_terminal_in      <= t;
        o_output_stop_in   <= os;
        o_forward_start_in <= st[0];
        o_reverse_start_in <= st[1];
    endtask

    // A request stands for one edge; the released code shows its inverse.
    task automatic request(input logic [1:0] m);
        @(posedge i_sys_clk);
        o_mode_req_valid <= 1'b1;
        o_mode_req       <= m;
        @(posedge i_sys_clk);
        o_mode_req_valid <= 1'b0;
        o_mode_req       <= ~m;
    endtask
endmodule

// ---- dms_pkg.sv ----
// Overview of operation
// R1: Setting 7 and interlock falling forces External mode, stopped or running.
// R2: In External mode the interlock on stops output, off resumes it.
// R3: After a forced External change, stop key with a fault resets the drive.
// R4: Interlock on with a start input on refuses a change into panel mode.
// R5: Leaving setting 7 restores the normal output-stop meaning of that input.
// R6: Output-stop input polarity is inverted when the polarity setting is 2.
// R7: Settings 0, 6, 7: panel/External switch on gives External, off panel.
// R8: Setting 6 accepts mode changes from switching inputs while running.
// R9: A terminal acts as panel/External switch only when assigned code 16.
// R10: Settings 1, 2, 3 and 4 ignore the panel/External switch input.
// R11: Precedence: setting, interlock, Net/Ext, Net/panel, panel/Ext, startup.
// R12: Settings 0, 2, 6 let the network switches enter Network mode.
// R13: Startup 10, setting 0 or 6, code 65: on gives panel, off Network.
// R14: Net/panel asking panel while Net/External is on gives Network.
// R15: Network substitutes panel or External by the panel/External input.
// R16: Startup 0 or 1, code 66: on gives Network, off gives External.
// R17: Net/External off gives panel if panel/External off, or follows 65.
// R18: Setting 7, interlock on: switching allowed, output stopped in External.
// R19: Setting 2 never enters panel mode.
// R20: Without an interlock terminal, setting 7 reads output-stop as interlock.
// R21: After reset the startup setting may select Network mode first.
// R22: The mode is evaluated every cycle and held in a registered output.
// R23: Outside setting 6, switching inputs change mode only when stopped with starts off.
package dms_pkg;

    localparam int SEL_W = 4;
    localparam int SU_W  = 4;
    localparam int FN_W  = 8;

    localparam logic [SEL_W-1:0] SEL_STD    = 4'h0;
    localparam logic [SEL_W-1:0] SEL_PU     = 4'h1;
    localparam logic [SEL_W-1:0] SEL_EXT    = 4'h2;
    localparam logic [SEL_W-1:0] SEL_COMB1  = 4'h3;
    localparam logic [SEL_W-1:0] SEL_COMB2  = 4'h4;
    localparam logic [SEL_W-1:0] SEL_SWITCH = 4'h6;
    localparam logic [SEL_W-1:0] SEL_ILK    = 4'h7;

    localparam logic [SU_W-1:0] SU_AS_SEL = 4'h0;
    localparam logic [SU_W-1:0] SU_NET    = 4'h1;
    localparam logic [SU_W-1:0] SU_NETPU  = 4'hA;

    localparam logic [FN_W-1:0] FN_ILK    = 8'h0C;
    localparam logic [FN_W-1:0] FN_PUEXT  = 8'h10;
    localparam logic [FN_W-1:0] FN_NETPU  = 8'h41;
    localparam logic [FN_W-1:0] FN_NETEXT = 8'h42;

    localparam logic [1:0] POL_INV    = 2'h2;
    localparam logic [1:0] NCS_OPTION = 2'h0;

    typedef enum logic [1:0] {
        MODE_EXT  = 2'b00,
        MODE_PU   = 2'b01,
        MODE_NET  = 2'b10,
        MODE_COMB = 2'b11
    } dms_mode_t;

endpackage

// ---- dms_selector.sv ----
`timescale 1ns/1ps
module dms_selector
    import dms_pkg::*;
#(
    parameter int NUM_TERM = 7
) (
    // Clock and reset
    input  wire logic                     I_SYS_CLK,
    input  wire logic                     I_RST_B,
    // Settings
    input  wire logic [SEL_W-1:0]         I_MODE_SELECT_SETTING,
    input  wire logic [SU_W-1:0]          I_NETWORK_STARTUP_SETTING,
    input  wire logic [1:0]               I_NETWORK_COMMAND_SOURCE_SETTING,
    input  wire logic [1:0]               I_OUTPUT_STOP_POLARITY_SETTING,
    input  wire logic [NUM_TERM*FN_W-1:0] I_TERMINAL_FUNCTION_ASSIGN,
    input  wire logic                     I_OPTION_FITTED,
    // Terminal pins
    input  wire logic [NUM_TERM-1:0]      I_TERMINAL_IN,
    input  wire logic                     I_OUTPUT_STOP_IN,
    input  wire logic                     I_FORWARD_START_IN,
    input  wire logic                     I_REVERSE_START_IN,
    // Drive status
    input  wire logic                     I_MOTOR_STOPPED,
    input  wire logic                     I_FAULT,
    // Panel and network
    input  wire logic                     I_STOP_KEY,
    input  wire logic                     I_MODE_REQ_VALID,
    input  wire logic [1:0]               I_MODE_REQ,
    // Results
    output logic [1:0]                    O_OPERATION_MODE,
    output logic                          O_OUTPUT_STOP,
    output logic                          O_FAULT_RESET,
    output logic                          O_REQ_REFUSED
);

    //--------------------------------------------------------------
    // Parameter check
    //--------------------------------------------------------------
    if (NUM_TERM < 1 || NUM_TERM > 16) begin : g_bad
        $error("NUM_TERM must lie between 1 and 16.");
    end

    localparam int PW = NUM_TERM + 3;

    //--------------------------------------------------------------
    // State
    //--------------------------------------------------------------
    logic [PW-1:0]   s1_q, s1_d;
    logic [PW-1:0]   s2_q, s2_d;
    dms_mode_t       mode_q, mode_d;
    logic            init_q, init_d;
    logic            forced_q, forced_d;
    logic            key_q, key_d;
    logic            stop_q, stop_d;
    logic            frst_q, frst_d;
    logic            refu_q, refu_d;

    // Terminals whose assigned function code equals the one asked for.
    function automatic logic [NUM_TERM-1:0] fn_hit(
        input logic [FN_W-1:0] code
    );
        logic [NUM_TERM-1:0] h;
        h = '0;
        for (int k = 0; k < NUM_TERM; k++) begin
            h[k] = (I_TERMINAL_FUNCTION_ASSIGN[k*FN_W +: FN_W] == code);
        end
        return h;
    endfunction

    //--------------------------------------------------------------
    // Decoded inputs
    //--------------------------------------------------------------
    logic [NUM_TERM-1:0] term;
    logic            fwd, rev, start_on, mrs_lvl;
    logic            ilk_a, ilk_mode, ilk_lvl, ilk_from_mrs;
    logic            x16_a, x65_a, x66_a, x16, x65, x66;
    logic            x16_use, x65_use, x66_use;
    logic            net_ok, may_switch, forced, from_req;
    dms_mode_t       tgt;
    logic            tgt_ok;

    assign term  = s2_q[PW-1:3];
    assign fwd   = s2_q[0];
    assign rev   = s2_q[1];
    assign start_on = fwd | rev;
    assign mrs_lvl  = s2_q[2] ^ (I_OUTPUT_STOP_POLARITY_SETTING == POL_INV); // [R6]

    assign ilk_a = |fn_hit(FN_ILK);
    assign x16_a = |fn_hit(FN_PUEXT); // [R9]
    assign x65_a = |fn_hit(FN_NETPU);
    assign x66_a = |fn_hit(FN_NETEXT);
    assign x16   = |(fn_hit(FN_PUEXT) & term);
    assign x65   = |(fn_hit(FN_NETPU) & term);
    assign x66   = |(fn_hit(FN_NETEXT) & term);

    assign ilk_mode     = (I_MODE_SELECT_SETTING == SEL_ILK);
    assign ilk_from_mrs = ilk_mode && !ilk_a; // [R20] [R5]
    assign ilk_lvl      = ilk_a ? |(fn_hit(FN_ILK) & term) : mrs_lvl;

    assign net_ok = !(I_NETWORK_COMMAND_SOURCE_SETTING == NCS_OPTION
                      && !I_OPTION_FITTED); // [R15]
    assign may_switch = (I_MOTOR_STOPPED && !start_on)
                        || (I_MODE_SELECT_SETTING == SEL_SWITCH); // [R23] [R8]

    assign x66_use = x66_a
        && (I_NETWORK_STARTUP_SETTING == SU_AS_SEL
            || I_NETWORK_STARTUP_SETTING == SU_NET)
        && (I_MODE_SELECT_SETTING == SEL_STD
            || I_MODE_SELECT_SETTING == SEL_EXT
            || I_MODE_SELECT_SETTING == SEL_SWITCH
            || I_MODE_SELECT_SETTING == SEL_ILK); // [R16]
    assign x65_use = x65_a
        && (I_NETWORK_STARTUP_SETTING == SU_NETPU)
        && (I_MODE_SELECT_SETTING == SEL_STD
            || I_MODE_SELECT_SETTING == SEL_SWITCH); // [R13] [R12]
    assign x16_use = x16_a
        && (I_MODE_SELECT_SETTING == SEL_STD
            || I_MODE_SELECT_SETTING == SEL_SWITCH
            || I_MODE_SELECT_SETTING == SEL_ILK); // [R7] [R10]

    //--------------------------------------------------------------
    // Target mode by precedence
    //--------------------------------------------------------------
    always_comb begin
        tgt      = mode_q;
        tgt_ok   = 1'b0;
        forced   = 1'b0;
        from_req = 1'b0;
        case (I_MODE_SELECT_SETTING) // [R11]
            SEL_PU: begin
                tgt    = MODE_PU; // [R10]
                tgt_ok = 1'b1;
                forced = 1'b1;
            end
            SEL_COMB1, SEL_COMB2: begin
                tgt    = MODE_COMB; // [R10]
                tgt_ok = 1'b1;
                forced = 1'b1;
            end
            SEL_STD, SEL_EXT, SEL_SWITCH, SEL_ILK: begin
                tgt_ok = 1'b1;
                if (ilk_mode && !ilk_lvl) begin
                    tgt    = MODE_EXT; // [R1]
                    forced = 1'b1;
                end else if (x66_use) begin
                    if (x66) begin
                        tgt = net_ok ? MODE_NET : MODE_PU; // [R16] [R15]
                    end else if (x65_a) begin
                        tgt = x65 ? MODE_PU : MODE_NET; // [R17]
                    end else if (x16_a && !x16) begin
                        tgt = MODE_PU; // [R17]
                    end else begin
                        tgt = MODE_EXT;
                    end
                end else if (x65_use) begin
                    if (x65 && !x66) begin
                        tgt = MODE_PU; // [R13]
                    end else if (x16_a) begin
                        tgt = x16 ? MODE_EXT : MODE_PU; // [R15]
                    end else begin
                        tgt = net_ok ? MODE_NET : MODE_PU; // [R14] [R15]
                    end
                end else if (x16_use) begin
                    tgt = x16 ? MODE_EXT : MODE_PU; // [R7]
                end else if (I_MODE_REQ_VALID) begin
                    tgt      = dms_mode_t'(I_MODE_REQ);
                    from_req = 1'b1;
                end else begin
                    tgt_ok = 1'b0;
                end
                if (I_MODE_SELECT_SETTING == SEL_EXT && tgt == MODE_PU) begin
                    tgt = MODE_EXT; // [R19]
                end
            end
            default: begin
                tgt_ok = 1'b0;
            end
        endcase
    end

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    logic refuse;
    logic pu_net_swap;

    always_comb begin
        s1_d = {I_TERMINAL_IN, I_OUTPUT_STOP_IN,
                I_REVERSE_START_IN, I_FORWARD_START_IN};
        s2_d     = s1_q;
        key_d    = I_STOP_KEY;
        init_d   = 1'b0;
        mode_d   = mode_q;
        forced_d = forced_q;
        refu_d   = 1'b0;
        pu_net_swap = (tgt == MODE_PU && mode_q == MODE_NET)
                      || (tgt == MODE_NET && mode_q == MODE_PU);
        refuse = 1'b0;
        if (tgt == MODE_PU && ilk_mode && ilk_lvl && start_on) begin
            refuse = 1'b1; // [R4]
        end
        if (from_req && tgt == MODE_COMB) begin
            refuse = 1'b1;
        end
        if (from_req && pu_net_swap
            && I_NETWORK_STARTUP_SETTING != SU_NETPU
            && I_MODE_SELECT_SETTING != SEL_SWITCH) begin
            refuse = 1'b1;
        end
        if (init_q) begin
            // Start-up mode, chosen while the pin synchronisers still hold their reset zeros.
            if (tgt_ok && forced) begin
                mode_d = tgt;
            end else if (I_MODE_SELECT_SETTING == SEL_STD
                         || I_MODE_SELECT_SETTING == SEL_EXT
                         || I_MODE_SELECT_SETTING == SEL_SWITCH) begin
                mode_d = (I_NETWORK_STARTUP_SETTING == SU_AS_SEL)
                         ? MODE_EXT : MODE_NET; // [R21]
            end else if (I_MODE_SELECT_SETTING == SEL_ILK) begin
                mode_d = (I_NETWORK_STARTUP_SETTING == SU_NET)
                         ? MODE_NET : MODE_EXT; // [R21]
            end else begin
                mode_d = MODE_EXT;
            end
        end else if (tgt_ok && tgt != mode_q) begin
            if (forced) begin
                mode_d = tgt;
            end else if (may_switch && !refuse) begin
                mode_d = tgt; // [R22] [R12]
            end else if (from_req) begin
                refu_d = 1'b1;
            end
        end
        if (ilk_mode && !ilk_lvl && mode_q != MODE_EXT) begin
            forced_d = 1'b1;
        end else if (!ilk_mode || ilk_lvl) begin
            forced_d = 1'b0;
        end
        stop_d = (ilk_mode && ilk_lvl && mode_d == MODE_EXT) // [R2] [R18]
                 || (!ilk_from_mrs && mrs_lvl); // [R5]
        frst_d = I_STOP_KEY && !key_q && I_FAULT
                 && forced_q && mode_q == MODE_EXT; // [R3]
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_B) begin
            s1_q     <= '0;
            s2_q     <= '0;
            mode_q   <= MODE_EXT;
            init_q   <= 1'b1;
            forced_q <= 1'b0;
            key_q    <= 1'b0;
            stop_q   <= 1'b0;
            frst_q   <= 1'b0;
            refu_q   <= 1'b0;
        end else begin
            s1_q     <= s1_d;
            s2_q     <= s2_d;
            mode_q   <= mode_d;
            init_q   <= init_d;
            forced_q <= forced_d;
            key_q    <= key_d;
            stop_q   <= stop_d;
            frst_q   <= frst_d;
            refu_q   <= refu_d;
        end
    end

    assign O_OPERATION_MODE = mode_q;
    assign O_OUTPUT_STOP    = stop_q;
    assign O_FAULT_RESET    = frst_q;
    assign O_REQ_REFUSED    = refu_q;

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RST_B);

    sequence s_key_press;
        !I_STOP_KEY ##1 (I_STOP_KEY && I_FAULT && forced_q
                         && mode_q == MODE_EXT);
    endsequence

    sequence s_run_fixed;
        !init_q && !I_MOTOR_STOPPED
        && (I_MODE_SELECT_SETTING == SEL_STD
            || I_MODE_SELECT_SETTING == SEL_EXT)
        ##1 $stable(I_MODE_SELECT_SETTING) && !I_MOTOR_STOPPED;
    endsequence

    // Checks other than chk_fault_reset wait for the start-up cycle, so that the reset values still
    // registered at the release edge are not taken for a wrong answer.
    chk_ilk_forces_ext: assert property ( // [R1]
        (!init_q && ilk_mode && !ilk_lvl) |=> mode_q == MODE_EXT
    ) else $error("Interlock off did not force External mode.");

    chk_ext_output_stop: assert property ( // [R2]
        (!init_q && ilk_mode && ilk_lvl)
        |=> (mode_q != MODE_EXT || O_OUTPUT_STOP)
    ) else $error("External mode with interlock on did not stop output.");

    chk_fault_reset: assert property ( // [R3]
        s_key_press |=> O_FAULT_RESET ##1 !O_FAULT_RESET
    ) else $error("Stop key did not give a one-cycle fault reset.");

    chk_no_panel_run: assert property ( // [R4]
        (!init_q && ilk_mode && ilk_lvl && start_on
         && mode_q != MODE_PU) |=> mode_q != MODE_PU
    ) else $error("Panel mode entered with a start input on.");

    chk_stop_polarity: assert property ( // [R6]
        (!init_q && !ilk_mode && I_OUTPUT_STOP_POLARITY_SETTING == POL_INV
         && !s2_q[2]) |=> O_OUTPUT_STOP
    ) else $error("Inverted output-stop input was not honoured.");

    chk_hold_running: assert property ( // [R23]
        s_run_fixed |-> $stable(mode_q)
    ) else $error("Mode changed while running outside switch-over.");

    chk_fixed_panel: assert property ( // [R10]
        (!init_q && I_MODE_SELECT_SETTING == SEL_PU) |=> mode_q == MODE_PU
    ) else $error("Fixed panel setting did not hold panel mode.");

    chk_fixed_comb: assert property ( // [R10]
        (!init_q && (I_MODE_SELECT_SETTING == SEL_COMB1
                     || I_MODE_SELECT_SETTING == SEL_COMB2))
        |=> mode_q == MODE_COMB
    ) else $error("Combined setting did not hold combined mode.");

    chk_never_panel: assert property ( // [R19]
        (!init_q && I_MODE_SELECT_SETTING == SEL_EXT
         && mode_q != MODE_PU) |=> mode_q != MODE_PU
    ) else $error("Setting 2 entered panel mode.");

    chk_netpu_panel: assert property ( // [R13]
        (!init_q && x65_use && x65 && !x66 && I_MOTOR_STOPPED
         && !start_on) |=> mode_q == MODE_PU
    ) else $error("Net/panel input on did not select panel mode.");

endmodule

// ---- drive_operation_mode_selector_tb_top.sv ----
`timescale 1ns/1ps
module drive_operation_mode_selector_tb_top;
    import dms_pkg::*;

    localparam int NT = 7;

    typedef struct packed {
        logic [3:0] sel;
        logic [3:0] su;
        logic [1:0] cfg;
        logic [3:0] term;
        logic       ostop;
        logic [1:0] pol;
        logic       nofit;
        dms_mode_t  mode;
        logic       stop;
    } dms_row_t;

    logic              clk     = 1'b0;
    logic              rst_b   = 1'b0;
    logic [SEL_W-1:0]  sel     = 4'h0;
    logic [SU_W-1:0]   su      = 4'h0;
    logic [1:0]        ncs     = 2'h1;
    logic [1:0]        pol     = 2'h0;
    logic [NT*FN_W-1:0] asg    = '0;
    logic              fit     = 1'b1;
    logic              stopped = 1'b1;
    logic              fault   = 1'b0;
    logic              key     = 1'b0;
    logic [NT-1:0]     term;
    logic              ostop_in, fwd, rev, rvalid;
    logic [1:0]        req, mode;
    logic              ostop, freset, refused, seen;
    int                fail_count = 0;
    int                num_checks = 0;
    int                cycles     = 0;
    dms_row_t          rows [0:23];

    always #20 clk = ~clk;

    dms_far_side #(.NUM_TERM(NT)) far (
        .i_sys_clk(clk), .o_terminal_in(term), .o_output_stop_in(ostop_in),
        .o_forward_start_in(fwd), .o_reverse_start_in(rev),
        .o_mode_req_valid(rvalid), .o_mode_req(req));

    dms_selector #(.NUM_TERM(NT)) DUT (
        .I_SYS_CLK(clk), .I_RST_B(rst_b), .I_MODE_SELECT_SETTING(sel),
        .I_NETWORK_STARTUP_SETTING(su),
        .I_NETWORK_COMMAND_SOURCE_SETTING(ncs),
        .I_OUTPUT_STOP_POLARITY_SETTING(pol),
        .I_TERMINAL_FUNCTION_ASSIGN(asg), .I_OPTION_FITTED(fit),
        .I_TERMINAL_IN(term), .I_OUTPUT_STOP_IN(ostop_in),
        .I_FORWARD_START_IN(fwd), .I_REVERSE_START_IN(rev),
        .I_MOTOR_STOPPED(stopped), .I_FAULT(fault), .I_STOP_KEY(key),
        .I_MODE_REQ_VALID(rvalid), .I_MODE_REQ(req),
        .O_OPERATION_MODE(mode), .O_OUTPUT_STOP(ostop),
        .O_FAULT_RESET(freset), .O_REQ_REFUSED(refused));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, got,
                     exp);
        end
    endtask

    // Terminal k of each layout: 0 interlock, 1 panel/ext, 2..3 network.
    function automatic logic [NT*FN_W-1:0] cfg_word(input logic [1:0] c);
        logic [NT*FN_W-1:0] w;
        w = '0;
        case (c)
            2'h0: w[23:0] = {FN_NETEXT, FN_PUEXT, FN_ILK};
            2'h1: w[31:16] = {FN_NETEXT, FN_NETPU};
            2'h2: w[7:0] = FN_ILK;
            default: w = '0;
        endcase
        return w;
    endfunction

    // The first three edges let the pin synchronisers settle.
    task automatic wait_out(input dms_mode_t m, input logic s);
        int n;
        n = 0;
        repeat (3) @(posedge clk);
        #1;
        while ((mode !== m || ostop !== s) && n < 12) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(8'(mode), 8'(m));
        check(8'(ostop), 8'(s));
    endtask

    task automatic apply_row(input dms_row_t r);
        @(posedge clk);
        sel     <= r.sel;
        su      <= r.su;
        asg     <= cfg_word(r.cfg);
        pol     <= r.pol;
        ncs     <= r.nofit ? 2'h0 : 2'h1;
        fit     <= ~r.nofit;
        stopped <= 1'b1;
        rst_b   <= 1'b0;
        far.set_pins({3'h0, r.term}, r.ostop, 2'h0);
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wait_out(r.mode, r.stop);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rows[0]  = '{4'h0,4'h0,2'h0,4'h2,1'b0,2'h0,1'b0,MODE_EXT,1'b0};
        rows[1]  = '{4'h0,4'h0,2'h0,4'h0,1'b0,2'h0,1'b0,MODE_PU,1'b0};
        rows[2]  = '{4'h0,4'h0,2'h0,4'h4,1'b0,2'h0,1'b0,MODE_NET,1'b0};
        rows[3]  = '{4'h1,4'h0,2'h0,4'h2,1'b0,2'h0,1'b0,MODE_PU,1'b0};
        rows[4]  = '{4'h3,4'h0,2'h0,4'h0,1'b0,2'h0,1'b0,MODE_COMB,1'b0};
        rows[5]  = '{4'h4,4'h0,2'h0,4'h2,1'b0,2'h0,1'b0,MODE_COMB,1'b0};
        rows[6]  = '{4'h2,4'h0,2'h0,4'h0,1'b0,2'h0,1'b0,MODE_EXT,1'b0};
        rows[7]  = '{4'h2,4'h0,2'h0,4'h4,1'b0,2'h0,1'b0,MODE_NET,1'b0};
        rows[8]  = '{4'h7,4'h0,2'h0,4'h0,1'b0,2'h0,1'b0,MODE_EXT,1'b0};
        rows[9]  = '{4'h7,4'h0,2'h0,4'h3,1'b0,2'h0,1'b0,MODE_EXT,1'b1};
        rows[10] = '{4'h7,4'h0,2'h0,4'h1,1'b0,2'h0,1'b0,MODE_PU,1'b0};
        rows[11] = '{4'h0,4'h0,2'h0,4'h4,1'b0,2'h0,1'b1,MODE_PU,1'b0};
        rows[12] = '{4'h0,4'hA,2'h1,4'h4,1'b0,2'h0,1'b0,MODE_PU,1'b0};
        rows[13] = '{4'h0,4'hA,2'h1,4'h0,1'b0,2'h0,1'b0,MODE_NET,1'b0};
        rows[14] = '{4'h0,4'hA,2'h1,4'hC,1'b0,2'h0,1'b0,MODE_NET,1'b0};
        rows[15] = '{4'h0,4'h0,2'h2,4'h0,1'b0,2'h0,1'b0,MODE_EXT,1'b0};
        rows[16] = '{4'h0,4'h1,2'h2,4'h0,1'b0,2'h0,1'b0,MODE_NET,1'b0};
        rows[17] = '{4'h7,4'h0,2'h3,4'h0,1'b0,2'h2,1'b0,MODE_EXT,1'b1};
        rows[18] = '{4'h7,4'h0,2'h3,4'h0,1'b0,2'h0,1'b0,MODE_EXT,1'b0};
        rows[19] = '{4'h0,4'h0,2'h3,4'h0,1'b0,2'h2,1'b0,MODE_EXT,1'b1};
        rows[20] = '{4'h0,4'h0,2'h0,4'h2,1'b0,2'h0,1'b0,MODE_EXT,1'b0};
        rows[21] = '{4'h7,4'h0,2'h0,4'h1,1'b0,2'h0,1'b0,MODE_PU,1'b0};
        rows[22] = '{4'h7,4'h0,2'h2,4'h1,1'b0,2'h0,1'b0,MODE_EXT,1'b1};
        rows[23] = '{4'h7,4'h0,2'h3,4'h0,1'b1,2'h0,1'b0,MODE_EXT,1'b1};
        repeat (10) @(posedge clk);
        for (int i = 0; i < 20; i++) begin
            apply_row(rows[i]);
        end
        // Switching gated while running, then switch-over mode.
        apply_row(rows[20]);
        @(posedge clk);
        stopped <= 1'b0;
        far.set_pins(7'h00, 1'b0, 2'h1);
        repeat (6) @(posedge clk);
        #1;
        check(8'(mode), 8'(MODE_EXT));
        @(posedge clk);
        stopped <= 1'b1;
        far.set_pins(7'h00, 1'b0, 2'h0);
        wait_out(MODE_PU, 1'b0);
        @(posedge clk);
        stopped <= 1'b0;
        sel     <= SEL_SWITCH;
        far.set_pins(7'h02, 1'b0, 2'h1);
        wait_out(MODE_EXT, 1'b0);
        // Forced change while running, fault reset, output stop.
        apply_row(rows[21]);
        @(posedge clk);
        stopped <= 1'b0;
        far.set_pins(7'h00, 1'b0, 2'h1);
        wait_out(MODE_EXT, 1'b0);
        @(posedge clk);
        fault <= 1'b1;
        key   <= 1'b1;
        seen = 1'b0;
        repeat (3) begin
            @(posedge clk);
            #1;
            seen = seen | (freset === 1'b1);
        end
        check(8'(seen), 8'h01);
        @(posedge clk);
        key   <= 1'b0;
        fault <= 1'b0;
        far.set_pins(7'h03, 1'b0, 2'h1);
        wait_out(MODE_EXT, 1'b1);
        far.set_pins(7'h02, 1'b0, 2'h1);
        wait_out(MODE_EXT, 1'b0);
        // Panel requests under the interlock.
        apply_row(rows[22]);
        far.set_pins(7'h01, 1'b0, 2'h2);
        repeat (3) @(posedge clk);
        far.request(MODE_PU);
        #1;
        check(8'(refused), 8'h01);
        far.set_pins(7'h01, 1'b0, 2'h0);
        repeat (3) @(posedge clk);
        far.request(MODE_PU);
        #1;
        check(8'(mode), 8'(MODE_PU));
        check(8'(refused), 8'h00);
        far.request(MODE_COMB);
        #1;
        check(8'(refused), 8'h01);
        far.request(MODE_NET);
        #1;
        check(8'(refused), 8'h01);
        check(8'(mode), 8'(MODE_PU));
        // Output-stop input as interlock, then back to its own meaning.
        apply_row(rows[23]);
        far.request(MODE_PU);
        wait_out(MODE_PU, 1'b0);
        @(posedge clk);
        sel <= SEL_STD;
        wait_out(MODE_PU, 1'b1);
        @(posedge clk);
        sel <= SEL_ILK;
        wait_out(MODE_PU, 1'b0);
        report_and_stop();
    end
endmodule
